//--- test/tirp_ir_load.sv
// Emitter load on the IR pin: counts pulses and measures segment lengths
`timescale 1ns/1ps
module tirp_ir_load (
  input  wire clk_i,
  input  wire rst_n_i,
  input  wire ir_i,
  output int  rises_o,
  output int  hi_len_o,
  output int  lo_len_o
);
  int   run;
  logic last;
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rises_o <= 0;
      hi_len_o <= 0;
      lo_len_o <= 0;
      run <= 0;
      last <= 1'b0;
    end else if (ir_i !== last) begin
      // Length of the segment that just ended
      if (last) hi_len_o <= run;
      else lo_len_o <= run;
      if (ir_i) rises_o <= rises_o + 1;
      run <= 1;
      last <= ir_i;
    end else begin
      run <= run + 1;
    end
  end
endmodule // tirp_ir_load

//--- test/tirp_timers_bench.sv
// Self-checking bench of the timer and IR/PWM block
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fails++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end
module tirp_timers_bench;
  logic        sys_clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic        two_clock_mode_i = 1'b1;
  logic [4:0]  addr_i = 5'h00;
  logic [7:0]  wdata_i = 8'h00;
  logic [2:0]  tmr_pin_i = 3'h0;
  logic [7:0]  d;
  wire  [7:0]  rdata_o;
  wire         ir_out_o;
  wire  [4:0]  irq_pending_o;
  wire  [11:0] irq_vector_o;
  int          fails = 0;
  int          checked = 0;
  int          n;
  int          rises;
  int          hi_len;
  int          lo_len;
  localparam logic [4:0] MAP [12] = '{5'h08, 5'h09, 5'h0A, 5'h0F, 5'h15, 5'h16, 5'h17, 5'h18, 5'h19,
                                      5'h1A, 5'h1B, 5'h1F};
  localparam logic [4:0] RWA [9] = '{5'h08, 5'h09, 5'h0F, 5'h1F, 5'h19, 5'h1A, 5'h1B, 5'h03, 5'h0A};
  localparam logic [7:0] RWE [9] = '{8'h07, 8'hF7, 8'hF8, 8'hF8, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'hFF};
  always #12.5 sys_clk_i = ~sys_clk_i;
  tirp_timers dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .two_clock_mode_i(two_clock_mode_i),
    .tmr_pin_i(tmr_pin_i), .ir_out_o(ir_out_o), .irq_pending_o(irq_pending_o), .irq_vector_o(irq_vector_o));
  tirp_ir_load load (.clk_i(sys_clk_i), .rst_n_i(rst_n_i), .ir_i(ir_out_o), .rises_o(rises),
    .hi_len_o(hi_len), .lo_len_o(lo_len));
  // ----------------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------------
  task wr(input [4:0] a, input [7:0] v);
    @(posedge sys_clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= v;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask
  task rd(input [4:0] a);
    @(posedge sys_clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  task chk_rd(input [4:0] a, input [7:0] e);
    rd(a);
    `CHK(d, e)
  endtask
  task end_of_test;
    $display("Comparisons %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task t_regs;
    foreach (MAP[i]) chk_rd(MAP[i], 8'h00);
    foreach (RWA[i]) begin
      wr(RWA[i], 8'hFF);
      chk_rd(RWA[i], RWE[i]);
      wr(RWA[i], 8'h00);
    end
  endtask
  // Times one overflow of a timer whose low byte is preset to F0
  task t_tmr(input [4:0] ca, input [7:0] cv, input [4:0] ta, input [7:0] tf, input [7:0] bh,
             input tc, input int lo, input int hi);
    @(posedge sys_clk_i);
    two_clock_mode_i <= tc;
    repeat (4) @(posedge sys_clk_i);
    wr(5'h0F, tf);
    wr(5'h1F, 8'h00);
    wr(5'h17, bh);
    wr(ca, cv);
    wr(ta, 8'hF0);
    n = 0;
    d = 8'h00;
    while ((d & tf) == 8'h00 && n < 400) begin
      rd(5'h1F);
      n += 2;
    end
    `CHK(n >= lo && n <= hi, 1'b1)
    `CHK(irq_pending_o[2:0], tf[5:3])
    rd(ta);
    `CHK(d >= 8'hF0, 1'b1)
    wr(ca, 8'h00);
    wr(5'h1F, 8'h00);
    chk_rd(5'h1F, 8'h00);
    wr(5'h0F, 8'h00);
  endtask
  task t_pwm;
    wr(5'h19, 8'h05);
    wr(5'h1A, 8'h02);
    wr(5'h0F, 8'hC0);
    wr(5'h0A, 8'h09);
    repeat (60) @(posedge sys_clk_i);
    `CHK(lo_len - hi_len, 3)
    `CHK(irq_pending_o[4:3], 2'b11)
    wr(5'h0A, 8'h01);
    repeat (40) @(posedge sys_clk_i);
    n = rises;
    repeat (40) @(posedge sys_clk_i);
    `CHK(rises, n)
    `CHK(ir_out_o, 1'b0)
    wr(5'h1F, 8'h80);
    repeat (3) @(posedge sys_clk_i);
    `CHK(irq_vector_o, 12'h01B)
    wr(5'h1F, 8'h00);
    repeat (3) @(posedge sys_clk_i);
    `CHK(irq_vector_o, 12'h000)
  endtask
  // Timer A counts pin edges, rising edges first, then falling edges
  task t_ext;
    wr(5'h08, 8'h06);
    wr(5'h15, 8'hF0);
    repeat (15) begin
      repeat (3) @(posedge sys_clk_i);
      tmr_pin_i <= 3'h1;
      repeat (3) @(posedge sys_clk_i);
      tmr_pin_i <= 3'h0;
    end
    repeat (5) @(posedge sys_clk_i);
    chk_rd(5'h15, 8'hFF);
    chk_rd(5'h1F, 8'h00);
    wr(5'h08, 8'h07);
    repeat (3) @(posedge sys_clk_i);
    tmr_pin_i <= 3'h1;
    repeat (6) @(posedge sys_clk_i);
    chk_rd(5'h15, 8'hFF);
    @(posedge sys_clk_i);
    tmr_pin_i <= 3'h0;
    repeat (6) @(posedge sys_clk_i);
    chk_rd(5'h15, 8'hF0);
    chk_rd(5'h1F, 8'h08);
    wr(5'h08, 8'h00);
    wr(5'h1F, 8'h00);
  endtask
  // Scaled segments: high steps every fourth tick, low every second tick
  task t_rate;
    wr(5'h1B, 8'h98);
    wr(5'h0A, 8'h09);
    repeat (80) @(posedge sys_clk_i);
    `CHK(hi_len, 12)
    `CHK(lo_len, 12)
    wr(5'h0A, 8'h00);
    repeat (40) @(posedge sys_clk_i);
    wr(5'h1B, 8'h00);
  endtask
  task t_gate;
    wr(5'h1A, 8'h09);
    wr(5'h0A, 8'h0B);
    repeat (80) @(posedge sys_clk_i);
    `CHK(hi_len, lo_len)
    wr(5'h0A, 8'h00);
    repeat (60) @(posedge sys_clk_i);
  endtask
  task t_carrier;
    wr(5'h19, 8'h14);
    wr(5'h1A, 8'h14);
    wr(5'h18, 8'h01);
    n = rises;
    wr(5'h0A, 8'h0D);
    repeat (200) @(posedge sys_clk_i);
    `CHK(rises - n > 12, 1'b1)
    `CHK(hi_len >= 1 && hi_len <= 2, 1'b1)
    chk_rd(5'h18, 8'h01);
    wr(5'h0A, 8'h00);
    repeat (100) @(posedge sys_clk_i);
  endtask
  initial begin
    repeat (12) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    t_regs;
    t_tmr(5'h08, 8'h04, 5'h15, 8'h08, 8'h00, 1'b1, 14, 22);
    t_tmr(5'h08, 8'h04, 5'h15, 8'h08, 8'h00, 1'b0, 30, 40);
    t_tmr(5'h09, 8'h40, 5'h16, 8'h10, 8'h00, 1'b1, 14, 22);
    t_tmr(5'h09, 8'hC0, 5'h16, 8'h10, 8'hFF, 1'b1, 14, 22);
    t_tmr(5'h09, 8'hC0, 5'h16, 8'h10, 8'hFE, 1'b1, 270, 280);
    t_tmr(5'h09, 8'h04, 5'h18, 8'h20, 8'h00, 1'b1, 14, 22);
    wr(5'h0A, 8'h80);
    t_tmr(5'h09, 8'h04, 5'h18, 8'h20, 8'h00, 1'b1, 30, 40);
    wr(5'h0A, 8'h00);
    t_ext;
    t_pwm;
    t_rate;
    t_gate;
    t_carrier;
    end_of_test;
  end
  initial begin
    #(25 * 20000);
    fails++;
    end_of_test;
  end
endmodule // tirp_timers_bench

//--- test/tirp_timers_sva.sv
// Port-level concurrent checks of the timer and IR/PWM block
`timescale 1ns/1ps
module tirp_timers_sva (
  input wire        sys_clk_i,
  input wire        rst_n_i,
  input wire [4:0]  addr_i,
  input wire [7:0]  wdata_i,
  input wire        wr_i,
  input wire        rd_i,
  input wire [7:0]  rdata_o,
  input wire        two_clock_mode_i,
  input wire [2:0]  tmr_pin_i,
  input wire        ir_out_o,
  input wire [4:0]  irq_pending_o,
  input wire [11:0] irq_vector_o
);
  // ----------------------------------------------------------------------
  // Register port and vector checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  chk_rd_idle: assert property (!rd_i |=> rdata_o == 8'h00)
    else $error("read data not cleared");
  chk_vec_high: assert property (irq_pending_o[3] |-> irq_vector_o == 12'h018)
    else $error("high vector wrong");
  chk_vec_low: assert property (irq_pending_o[4:3] == 2'b10 |-> irq_vector_o == 12'h01B)
    else $error("low vector wrong");
  chk_vec_none: assert property (irq_pending_o[4:3] == 2'b00 |-> irq_vector_o == 12'h000)
    else $error("vector not idle");
  chk_unmapped_read: assert property (rd_i && addr_i < 5'h08 |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  chk_a_ctl_zero: assert property (rd_i && addr_i == 5'h08 |=> rdata_o[7:3] == 5'h00)
    else $error("timer A control high bits set");
  chk_bc_gap: assert property (rd_i && addr_i == 5'h09 |=> !rdata_o[3])
    else $error("B/C control bit 3 set");
  chk_flag_low: assert property (rd_i && (addr_i == 5'h0F || addr_i == 5'h1F) |=> rdata_o[2:0] == 3'h0)
    else $error("mask or status low bits set");
  chk_mask_rw: assert property (wr_i && addr_i == 5'h0F ##2 rd_i && addr_i == 5'h0F
    |=> rdata_o == ($past(wdata_i, 3) & 8'hF8))
    else $error("mask readback wrong");
endmodule // tirp_timers_sva
bind tirp_timers tirp_timers_sva u_sva (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .two_clock_mode_i(two_clock_mode_i),
  .tmr_pin_i(tmr_pin_i), .ir_out_o(ir_out_o), .irq_pending_o(irq_pending_o), .irq_vector_o(irq_vector_o));

//--- verilog/tirp_regs.vh
// Register map, field positions and reset values of the timer and IR/PWM block
`ifndef TIRP_REGS_VH
`define TIRP_REGS_VH
// ----------------------------------------------------------------------
// Offsets
// ----------------------------------------------------------------------
`define TIRP_CMP_A_CTL 5'h08
`define TIRP_BC_CTL    5'h09
`define TIRP_IR_CTL    5'h0A
`define TIRP_MASK      5'h0F
`define TIRP_A_CNT     5'h15
`define TIRP_BL_CNT    5'h16
`define TIRP_BH_CNT    5'h17
`define TIRP_C_CNT     5'h18
`define TIRP_LOW_VAL   5'h19
`define TIRP_HIGH_VAL  5'h1A
`define TIRP_RATE      5'h1B
`define TIRP_STATUS    5'h1F
// ----------------------------------------------------------------------
// Fields and values
// ----------------------------------------------------------------------
`define TIRP_RST       8'h00
`define TIRP_EN        2
`define TIRP_TS        1
`define TIRP_TE        0
`define TIRP_B_HE      7
`define TIRP_B_EN      6
`define TIRP_B_TS      5
`define TIRP_B_TE      4
`define TIRP_SC_EN     7
`define TIRP_SC_LSB    4
`define TIRP_IRE       3
`define TIRP_HF        2
`define TIRP_LGP       1
`define TIRP_OUTE      0
`define TIRP_LS_EN     3
`define TIRP_LS_LSB    0
`define TIRP_FLAG_LSB  3
`define TIRP_FLAG_MSK  8'hF8
`define TIRP_VEC_HIGH  12'h018
`define TIRP_VEC_LOW   12'h01B
`define TIRP_VEC_NONE  12'h000
`endif

//--- verilog/tirp_timers.v
// Three reloadable timers and the IR carrier / PWM waveform generator
`timescale 1ns/1ps
`include "tirp_regs.vh"
module tirp_timers (
  input  wire        sys_clk_i,
  input  wire        rst_n_i,
  input  wire [4:0]  addr_i,
  input  wire [7:0]  wdata_i,
  input  wire        wr_i,
  input  wire        rd_i,
  output wire [7:0]  rdata_o,
  input  wire        two_clock_mode_i,
  input  wire [2:0]  tmr_pin_i,
  output wire        ir_out_o,
  output wire [4:0]  irq_pending_o,
  output wire [11:0] irq_vector_o
);
  // ----------------------------------------------------------------------
  // Control and status registers
  // ----------------------------------------------------------------------
  reg [7:0]  a_ctl_reg;
  reg [7:0]  bc_ctl_reg;
  reg [7:0]  ir_ctl_reg;
  reg [7:0]  rate_reg;
  reg [7:0]  mask_reg;
  reg [7:0]  stat_reg;

  // ----------------------------------------------------------------------
  // Timer counts and presets
  // ----------------------------------------------------------------------
  reg [7:0]  a_cnt_reg;
  reg [7:0]  a_pre_reg;
  reg [7:0]  bl_cnt_reg;
  reg [7:0]  bl_pre_reg;
  reg [7:0]  bh_cnt_reg;
  reg [7:0]  bh_pre_reg;
  reg [7:0]  c_cnt_reg;
  reg [7:0]  c_pre_reg;

  // ----------------------------------------------------------------------
  // Waveform sequencer and output state
  // ----------------------------------------------------------------------
  reg [7:0]  low_val_reg;
  reg [7:0]  high_val_reg;
  reg [7:0]  hcnt_reg;
  reg [7:0]  lcnt_reg;
  reg [7:0]  pre_reg;
  reg [7:0]  rdata_reg;
  reg [7:0]  rdata_next;
  reg [7:0]  stat_next;
  reg [4:0]  pend_reg;
  reg [11:0] vec_reg;
  reg        run_reg;
  reg        phase_reg;
  reg        lgp_on_reg;
  reg        carrier_reg;
  reg        div_reg;
  reg        ir_out_reg;

  // ----------------------------------------------------------------------
  // Synchronisers and pin edges
  // ----------------------------------------------------------------------
  reg [1:0]  mode_sync_reg;
  reg [2:0]  s1_reg;
  reg [2:0]  s2_reg;
  reg [2:0]  s3_reg;
  wire [2:0] ext_edge;
  wire [2:0] edge_sel;

  // ----------------------------------------------------------------------
  // Timer clock and prescaler
  // ----------------------------------------------------------------------
  // Full rate in two-clock mode, every other cycle in four-clock mode
  wire tick = mode_sync_reg[1] | div_reg;

  // Scaled rate fires once every 2^(sel+1) ticks, or every tick when disabled
  function scale_hit;
    input       en;
    input [2:0] sel;
    input [7:0] p;
    reg   [7:0] m;
    begin
      m = (8'h02 << sel) - 8'h01;
      scale_hit = ~en | ((p & m) == m);
    end
  endfunction

  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_sync_reg <= 2'b00;
      div_reg       <= 1'b0;
      pre_reg       <= `TIRP_RST;
    end else begin
      mode_sync_reg <= {mode_sync_reg[0], two_clock_mode_i};
      div_reg       <= ~div_reg;
      if (tick) begin
        pre_reg <= pre_reg + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------------
  // External count pins
  // ----------------------------------------------------------------------
  assign edge_sel = {bc_ctl_reg[`TIRP_TE], bc_ctl_reg[`TIRP_B_TE], a_ctl_reg[`TIRP_TE]};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_pin
      always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          s1_reg[gi] <= 1'b0;
          s2_reg[gi] <= 1'b0;
          s3_reg[gi] <= 1'b0;
        end else begin
          s1_reg[gi] <= tmr_pin_i[gi];
          s2_reg[gi] <= s1_reg[gi];
          s3_reg[gi] <= s2_reg[gi];
        end
      end
      // Edge select 0 counts rising edges, 1 falling edges
      assign ext_edge[gi] = edge_sel[gi] ? (s3_reg[gi] & ~s2_reg[gi])
                                         : (~s3_reg[gi] & s2_reg[gi]);
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Step, wrap and phase events
  // ----------------------------------------------------------------------
  wire wr_a    = wr_i & (addr_i == `TIRP_A_CNT);
  wire wr_bl   = wr_i & (addr_i == `TIRP_BL_CNT);
  wire wr_bh   = wr_i & (addr_i == `TIRP_BH_CNT);
  wire wr_c    = wr_i & (addr_i == `TIRP_C_CNT);
  wire ir_mode = ir_ctl_reg[`TIRP_HF] & ir_ctl_reg[`TIRP_IRE];
  wire b16     = bc_ctl_reg[`TIRP_B_HE];
  wire low_gating_select     = ir_ctl_reg[`TIRP_LGP];

  wire a_step = a_ctl_reg[`TIRP_EN] & (a_ctl_reg[`TIRP_TS] ? ext_edge[0] : tick);
  wire a_wrap = a_step & (a_cnt_reg == 8'hFF);
  wire b_step = bc_ctl_reg[`TIRP_B_EN] & (bc_ctl_reg[`TIRP_B_TS] ? ext_edge[1] : tick);
  wire b_lo_ff = b_step & (bl_cnt_reg == 8'hFF);
  wire b_wrap = b_lo_ff & (~b16 | (bh_cnt_reg == 8'hFF));
  wire c_hit  = tick & scale_hit(ir_ctl_reg[`TIRP_SC_EN], ir_ctl_reg[6:`TIRP_SC_LSB], pre_reg);
  wire c_step = ~ir_mode & bc_ctl_reg[`TIRP_EN] & (bc_ctl_reg[`TIRP_TS] ? ext_edge[2] : c_hit);
  wire c_wrap = c_step & (c_cnt_reg == 8'hFF);
  wire h_hit  = tick & scale_hit(rate_reg[`TIRP_SC_EN], rate_reg[6:`TIRP_SC_LSB], pre_reg);
  wire l_hit  = tick & scale_hit(rate_reg[`TIRP_LS_EN], rate_reg[2:`TIRP_LS_LSB], pre_reg);
  wire h_under = run_reg & phase_reg & ~low_gating_select & h_hit & (hcnt_reg == 8'h00);
  wire l_under = run_reg & ~phase_reg & l_hit & (lcnt_reg == 8'h00);

  // ----------------------------------------------------------------------
  // Timer A
  // ----------------------------------------------------------------------
  // Count and preset load together, so a write restarts the period
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      a_cnt_reg <= `TIRP_RST;
      a_pre_reg <= `TIRP_RST;
    end else if (wr_a) begin
      a_cnt_reg <= wdata_i;
      a_pre_reg <= wdata_i;
    end else if (a_wrap) begin
      a_cnt_reg <= a_pre_reg;
    end else if (a_step) begin
      a_cnt_reg <= a_cnt_reg + 8'h01;
    end
  end

  // ----------------------------------------------------------------------
  // Timer B, low byte and chained high byte
  // ----------------------------------------------------------------------
  // In 8-bit mode the high byte keeps its written value and never steps
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bl_cnt_reg <= `TIRP_RST;
      bl_pre_reg <= `TIRP_RST;
      bh_cnt_reg <= `TIRP_RST;
      bh_pre_reg <= `TIRP_RST;
    end else begin
      if (wr_bl) begin
        bl_cnt_reg <= wdata_i;
        bl_pre_reg <= wdata_i;
      end else if (b_wrap) begin
        bl_cnt_reg <= bl_pre_reg;
      end else if (b_step) begin
        bl_cnt_reg <= bl_cnt_reg + 8'h01;
      end
      if (wr_bh) begin
        bh_cnt_reg <= wdata_i;
        bh_pre_reg <= wdata_i;
      end else if (b_wrap & b16) begin
        bh_cnt_reg <= bh_pre_reg;
      end else if (b_lo_ff & b16) begin
        bh_cnt_reg <= bh_cnt_reg + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Timer C and carrier
  // ----------------------------------------------------------------------
  // In IR mode the count runs down from the preset and each pass through
  // zero flips the carrier, so a half period is (1 + preset) scaled ticks
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      c_cnt_reg   <= `TIRP_RST;
      c_pre_reg   <= `TIRP_RST;
      carrier_reg <= 1'b0;
    end else if (wr_c) begin
      c_cnt_reg <= wdata_i;
      c_pre_reg <= wdata_i;
    end else if (ir_mode) begin
      if (c_hit) begin
        if (c_cnt_reg == 8'h00) begin
          c_cnt_reg   <= c_pre_reg;
          carrier_reg <= ~carrier_reg;
        end else begin
          c_cnt_reg <= c_cnt_reg - 8'h01;
        end
      end
    end else begin
      carrier_reg <= 1'b0;
      if (c_wrap) begin
        c_cnt_reg <= c_pre_reg;
      end else if (c_step) begin
        c_cnt_reg <= c_cnt_reg + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------------
  // High-time / low-time sequencer
  // ----------------------------------------------------------------------
  // Clearing IR enable only stops the run at the underflow ending a segment,
  // so a steady-level pulse is never cut short; with HF set the carrier is cleared at once
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      run_reg    <= 1'b0;
      phase_reg  <= 1'b0;
      lgp_on_reg <= 1'b0;
      hcnt_reg   <= `TIRP_RST;
      lcnt_reg   <= `TIRP_RST;
    end else if (!run_reg) begin
      if (ir_ctl_reg[`TIRP_IRE]) begin
        run_reg    <= 1'b1;
        phase_reg  <= 1'b1;
        lgp_on_reg <= 1'b1;
        hcnt_reg   <= high_val_reg;
        lcnt_reg   <= low_val_reg;
      end
    end else if (phase_reg) begin
      if (low_gating_select) begin
        phase_reg <= 1'b0;
        lcnt_reg  <= low_val_reg;
      end else if (h_under) begin
        phase_reg <= 1'b0;
        lcnt_reg  <= low_val_reg;
        run_reg   <= ir_ctl_reg[`TIRP_IRE];
      end else if (h_hit) begin
        hcnt_reg <= hcnt_reg - 8'h01;
      end
    end else if (l_under) begin
      if (low_gating_select) begin
        lgp_on_reg <= ~lgp_on_reg;
        lcnt_reg   <= low_val_reg;
        run_reg    <= ir_ctl_reg[`TIRP_IRE];
      end else begin
        phase_reg <= 1'b1;
        hcnt_reg  <= high_val_reg;
      end
    end else if (l_hit) begin
      lcnt_reg <= lcnt_reg - 8'h01;
    end
  end

  // Active segment carries the carrier or a steady high level
  wire seg_on  = low_gating_select ? (~phase_reg & lgp_on_reg) : phase_reg;
  wire wave_on = seg_on & (ir_ctl_reg[`TIRP_HF] ? carrier_reg : 1'b1);

  // ----------------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------------
  always @* begin
    stat_next = stat_reg;
    if (wr_i && (addr_i == `TIRP_STATUS)) begin
      stat_next = wdata_i & `TIRP_FLAG_MSK;
    end
    // Hardware set wins over a software write in the same cycle
    stat_next = stat_next | {l_under, h_under, c_wrap, b_wrap, a_wrap, 3'b000};
  end

  // ----------------------------------------------------------------------
  // Read-back multiplexer
  // ----------------------------------------------------------------------
  always @* begin
    rdata_next = 8'h00;
    if (addr_i == `TIRP_CMP_A_CTL) begin
      rdata_next = a_ctl_reg;
    end else if (addr_i == `TIRP_BC_CTL) begin
      rdata_next = bc_ctl_reg;
    end else if (addr_i == `TIRP_IR_CTL) begin
      rdata_next = ir_ctl_reg;
    end else if (addr_i == `TIRP_MASK) begin
      rdata_next = mask_reg;
    end else if (addr_i == `TIRP_A_CNT) begin
      rdata_next = a_cnt_reg;
    end else if (addr_i == `TIRP_BL_CNT) begin
      rdata_next = bl_cnt_reg;
    end else if (addr_i == `TIRP_BH_CNT) begin
      rdata_next = bh_cnt_reg;
    end else if (addr_i == `TIRP_C_CNT) begin
      rdata_next = ir_mode ? c_pre_reg : c_cnt_reg;
    end else if (addr_i == `TIRP_LOW_VAL) begin
      rdata_next = low_val_reg;
    end else if (addr_i == `TIRP_HIGH_VAL) begin
      rdata_next = high_val_reg;
    end else if (addr_i == `TIRP_RATE) begin
      rdata_next = rate_reg;
    end else if (addr_i == `TIRP_STATUS) begin
      rdata_next = stat_reg;
    end
  end

  // ----------------------------------------------------------------------
  // Register writes and registered outputs
  // ----------------------------------------------------------------------
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      a_ctl_reg    <= `TIRP_RST;
      bc_ctl_reg   <= `TIRP_RST;
      ir_ctl_reg   <= `TIRP_RST;
      rate_reg     <= `TIRP_RST;
      mask_reg     <= `TIRP_RST;
      stat_reg     <= `TIRP_RST;
      low_val_reg  <= `TIRP_RST;
      high_val_reg <= `TIRP_RST;
      rdata_reg    <= `TIRP_RST;
      pend_reg     <= 5'h00;
      vec_reg      <= `TIRP_VEC_NONE;
      ir_out_reg   <= 1'b0;
    end else begin
      stat_reg <= stat_next;
      if (wr_i) begin
        if (addr_i == `TIRP_CMP_A_CTL) begin
          a_ctl_reg <= {5'h00, wdata_i[2:0]};
        end else if (addr_i == `TIRP_BC_CTL) begin
          bc_ctl_reg <= {wdata_i[7:4], 1'b0, wdata_i[2:0]};
        end else if (addr_i == `TIRP_IR_CTL) begin
          ir_ctl_reg <= wdata_i;
        end else if (addr_i == `TIRP_MASK) begin
          mask_reg <= wdata_i & `TIRP_FLAG_MSK;
        end else if (addr_i == `TIRP_LOW_VAL) begin
          low_val_reg <= wdata_i;
        end else if (addr_i == `TIRP_HIGH_VAL) begin
          high_val_reg <= wdata_i;
        end else if (addr_i == `TIRP_RATE) begin
          rate_reg <= wdata_i;
        end
      end
      rdata_reg  <= rd_i ? rdata_next : 8'h00;
      pend_reg   <= stat_reg[7:3] & mask_reg[7:3];
      // Registered pin level hides phase and carrier switching glitches
      ir_out_reg <= ir_ctl_reg[`TIRP_OUTE] & run_reg & wave_on;
      // High-time request wins when both are pending
      if (stat_reg[6] & mask_reg[6]) begin
        vec_reg <= `TIRP_VEC_HIGH;
      end else if (stat_reg[7] & mask_reg[7]) begin
        vec_reg <= `TIRP_VEC_LOW;
      end else begin
        vec_reg <= `TIRP_VEC_NONE;
      end
    end
  end

  assign rdata_o       = rdata_reg;
  assign ir_out_o      = ir_out_reg;
  assign irq_pending_o = pend_reg;
  assign irq_vector_o  = vec_reg;

endmodule // tirp_timers
